//--- hdl/pst_pkg.sv
// shared constants and types for the synthesizer tuning control block
// assumes a single 10 MHz clock; serial pins and the rf input are asynchronous
package pst_pkg;

  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned BAND_W = 4;
  localparam int unsigned DIV_W = 15;
  localparam int unsigned CNT_W = 6;

  // frame positions counted in serial clock pulses
  localparam logic [5:0] BAND_PULSE = 6'h04;
  localparam logic [5:0] SHORT_PULSE = 6'h12;
  localparam logic [5:0] DIV_PULSE = 6'h13;
  localparam logic [5:0] FEAT_PULSE = 6'h22;

  // feature bit positions in the shift register after the last accepted pulse
  localparam int unsigned POS_PUMP = 8;
  localparam int unsigned POS_FUNC_LO = 9;
  localparam int unsigned POS_FUNC_HI = 10;
  localparam int unsigned POS_ROUTE = 12;
  localparam int unsigned POS_REF_SEL = 13;
  localparam int unsigned POS_SHORT_MSB = 14;

  localparam logic [14:0] POR_RATIO = 15'h0100;
  localparam logic [2:0] PRESCALE_TOP = 3'h7;
  localparam logic [9:0] REF_TOP_LO = 10'h1ff;
  localparam logic [9:0] REF_TOP_HI = 10'h3ff;
  localparam int unsigned REF_SQ_LO = 8;
  localparam int unsigned REF_SQ_HI = 9;

  // comparator offset pulse width and phase error tolerance, in cycles
  localparam logic [3:0] OFFSET_CYC = 4'h2;
  localparam logic [3:0] LOCK_TOL_CYC = 4'h4;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_SHIFT = 2'b10
  } pst_rx_t;

  typedef enum logic [1:0] {
    CMP_NORMAL = 2'b00,
    CMP_HIZ = 2'b01,
    CMP_UP_ONLY = 2'b10,
    CMP_DN_ONLY = 2'b11
  } pst_cmp_t;

endpackage

//--- hdl/pst_divider.sv
// prescaler by eight and presettable down-counter with second ratio latch
// assumes hf_level is already synchronised to clock
`timescale 1ns/1ps
module pst_divider (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic hf_level,
  input wire logic [14:0] ratio_a,
  output logic div_pulse,
  output logic half_divider_freq
);

  typedef struct packed {
    logic prev;
    logic [2:0] pre_cnt;
    logic [14:0] cnt;
    logic [14:0] ratio_b;
    logic pulse;
    logic half;
  } pst_div_st_t;

  pst_div_st_t s_q;
  pst_div_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.prev = hf_level;
    s_d.pulse = 1'b0;
    if (hf_level && !s_q.prev) begin
      s_d.pre_cnt = s_q.pre_cnt + 3'h1; // R20
      if (s_q.pre_cnt == pst_pkg::PRESCALE_TOP) begin
        if (s_q.cnt == 15'h0000) begin
          // ratio is the plain binary value of the latch
          s_d.cnt = s_q.ratio_b - 15'h0001; // R16 R18
          s_d.ratio_b = ratio_a; // R17
          s_d.pulse = 1'b1;
          s_d.half = !s_q.half;
        end else begin
          s_d.cnt = s_q.cnt - 15'h0001; // R16
        end
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.ratio_b <= pst_pkg::POR_RATIO; // R03
    end else begin
      s_q <= s_d;
    end
  end

  assign div_pulse = s_q.pulse;
  assign half_divider_freq = s_q.half;

endmodule

//--- hdl/pst_ctrl.sv
// three-wire receiver, feature latches, reference divider, comparator, lock detector
// assumes serial pins and rf input are asynchronous to the 10 MHz clock
`timescale 1ns/1ps
// Overview of operation
// R01: 34-bit frame loads ratio at pulse 19
// R02: feature bits latched at pulse 34 fall
// R03: power-on resets receiver, ratio 256, features
// R04: malformed frames keep only completed fields
// R05: bits beyond 34 are dropped
// R06: 18-bit frame clears divider msb
// R07: 19-bit frame carries full 15-bit ratio
// R08: controller never programs ratio below 17
// R09: unused and trailing bits are ignored
// R10: pump bit one selects low current
// R11: two bits select comparator output mode
// R12: comparator up when fast, offset pulse
// R13: routing puts reference, half divider on bands
// R14: controller sets bands two, three when routing
// R15: reference ratio 512 or 1024, long frames
// R16: down-counter reloads from second latch at zero
// R17: second latch loads synchronous to divider
// R18: ratio is plain binary of divider bits
// R19: lock low when locked, unlock immediate
// R20: prescaler divides input by eight
// R21: enable rise starts frame, bands at 4
// R22: enable fall after 18 loads, clears msb
// R23: data sampled on serial clock rising edge
module pst_ctrl #(
  parameter logic FIXED_REF_1024 = 1'b0
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic serial_in_line,
  input wire logic serial_shift_clock,
  input wire logic serial_enable,
  input wire logic hf_in,
  output logic [3:0] band_switch_out,
  output logic pump_up,
  output logic pump_down,
  output logic pump_current_select,
  output logic lock_out
);

  typedef struct packed {
    logic [2:0] en_sync;
    logic [2:0] clk_sync;
    logic [2:0] dat_sync;
    logic [2:0] hf_sync;
    logic en_lvl;
    logic clk_lvl;
    logic dat_lvl;
    logic hf_lvl;
    pst_pkg::pst_rx_t rx;
    logic [5:0] bit_cnt;
    logic [14:0] shreg;
    logic [3:0] band;
    logic [14:0] ratio_a;
    logic pump_low;
    logic func_lo;
    logic func_hi;
    logic route;
    logic ref_sel;
    logic [9:0] ref_cnt;
    logic up;
    logic dn;
    logic [3:0] offs_cnt;
    logic [3:0] err_cnt;
    logic clean;
    logic lock;
    logic [3:0] band_out;
    logic pump_up_o;
    logic pump_dn_o;
  } pst_st_t;

  pst_st_t s_q;
  pst_st_t s_d;
  logic div_pulse;
  logic half_divider_freq;
  logic en_rise;
  logic en_fall;
  logic clk_rise;
  logic clk_fall;
  logic ref_tick;
  logic ref_sq;
  logic unlock;
  logic [9:0] ref_top;

  pst_divider u_div (
    .clock(clock),
    .arst_n(arst_n),
    .hf_level(s_q.hf_lvl),
    .ratio_a(s_q.ratio_a),
    .div_pulse(div_pulse),
    .half_divider_freq(half_divider_freq)
  );

  always_comb begin
    s_d = s_q;
    // three stages per pin; a level counts once the last two agree
    s_d.en_sync = {s_q.en_sync[1:0], serial_enable};
    s_d.clk_sync = {s_q.clk_sync[1:0], serial_shift_clock};
    s_d.dat_sync = {s_q.dat_sync[1:0], serial_in_line};
    s_d.hf_sync = {s_q.hf_sync[1:0], hf_in};
    if (s_q.en_sync[1] == s_q.en_sync[2]) begin
      s_d.en_lvl = s_q.en_sync[2];
    end
    if (s_q.clk_sync[1] == s_q.clk_sync[2]) begin
      s_d.clk_lvl = s_q.clk_sync[2];
    end
    if (s_q.dat_sync[1] == s_q.dat_sync[2]) begin
      s_d.dat_lvl = s_q.dat_sync[2];
    end
    if (s_q.hf_sync[1] == s_q.hf_sync[2]) begin
      s_d.hf_lvl = s_q.hf_sync[2];
    end
    en_rise = s_d.en_lvl && !s_q.en_lvl;
    en_fall = !s_d.en_lvl && s_q.en_lvl;
    clk_rise = s_d.clk_lvl && !s_q.clk_lvl && s_q.en_lvl;
    clk_fall = !s_d.clk_lvl && s_q.clk_lvl;

    // serial receiver
    case (s_q.rx)
      pst_pkg::RX_IDLE: begin
        if (en_rise) begin
          s_d.rx = pst_pkg::RX_SHIFT; // R21
          s_d.bit_cnt = '0;
          s_d.shreg = '0;
        end
      end
      pst_pkg::RX_SHIFT: begin
        if (en_fall) begin
          // a short frame keeps whatever fields completed before this point
          s_d.rx = pst_pkg::RX_IDLE; // R04
          if (s_q.bit_cnt == pst_pkg::SHORT_PULSE) begin
            s_d.ratio_a = {1'b0, s_q.shreg[13:0]}; // R22 R06
          end
          if (s_q.bit_cnt >= pst_pkg::SHORT_PULSE && s_q.bit_cnt < pst_pkg::FEAT_PULSE) begin
            s_d.ref_sel = 1'b0; // R15
          end
        end else if (clk_rise && s_q.bit_cnt < pst_pkg::FEAT_PULSE) begin
          s_d.shreg = {s_q.shreg[13:0], s_q.dat_lvl}; // R23
          s_d.bit_cnt = s_q.bit_cnt + 6'h01; // R05
        end else if (clk_fall) begin
          if (s_q.bit_cnt == pst_pkg::BAND_PULSE) begin
            s_d.band = s_q.shreg[3:0]; // R21
          end
          if (s_q.bit_cnt == pst_pkg::DIV_PULSE) begin
            s_d.ratio_a = s_q.shreg; // R01 R07
          end
          if (s_q.bit_cnt == pst_pkg::FEAT_PULSE) begin
            // unused slots and trailing bits are simply never picked up
            s_d.pump_low = s_q.shreg[pst_pkg::POS_PUMP]; // R02 R09
            s_d.func_lo = s_q.shreg[pst_pkg::POS_FUNC_LO]; // R02
            s_d.func_hi = s_q.shreg[pst_pkg::POS_FUNC_HI]; // R02
            s_d.route = s_q.shreg[pst_pkg::POS_ROUTE]; // R02
            s_d.ref_sel = s_q.shreg[pst_pkg::POS_REF_SEL]; // R02 R15
          end
        end
      end
      default: begin
        s_d.rx = pst_pkg::RX_IDLE;
      end
    endcase

    // reference divider, the fixed variant ignores the select bit
    ref_top = (s_q.ref_sel || FIXED_REF_1024) ? pst_pkg::REF_TOP_HI : pst_pkg::REF_TOP_LO; // R15
    ref_tick = (s_q.ref_cnt >= ref_top);
    ref_sq = (s_q.ref_sel || FIXED_REF_1024) ? s_q.ref_cnt[pst_pkg::REF_SQ_HI] :
             s_q.ref_cnt[pst_pkg::REF_SQ_LO];
    s_d.ref_cnt = ref_tick ? '0 : s_q.ref_cnt + 10'h001;

    // phase and frequency comparator
    s_d.up = s_q.up || div_pulse; // R12
    s_d.dn = s_q.dn || ref_tick; // R12
    if (s_d.up && s_d.dn) begin
      s_d.up = 1'b0;
      s_d.dn = 1'b0;
    end
    if (ref_tick) begin
      s_d.offs_cnt = pst_pkg::OFFSET_CYC; // R12
    end else if (s_q.offs_cnt != 4'h0) begin
      s_d.offs_cnt = s_q.offs_cnt - 4'h1;
    end
    case (pst_pkg::pst_cmp_t'({s_q.func_hi, s_q.func_lo}))
      pst_pkg::CMP_NORMAL: begin
        s_d.pump_up_o = s_q.up || (s_q.offs_cnt != 4'h0); // R11 R12
        s_d.pump_dn_o = s_q.dn;
      end
      pst_pkg::CMP_HIZ: begin
        s_d.pump_up_o = 1'b0; // R11
        s_d.pump_dn_o = 1'b0;
      end
      pst_pkg::CMP_UP_ONLY: begin
        s_d.pump_up_o = 1'b1; // R11
        s_d.pump_dn_o = 1'b0;
      end
      default: begin
        s_d.pump_up_o = 1'b0; // R11
        s_d.pump_dn_o = 1'b1;
      end
    endcase

    // lock detector: a one-sided error lasting the tolerance or longer is an unlock
    if (s_q.up != s_q.dn) begin
      s_d.err_cnt = (s_q.err_cnt == pst_pkg::LOCK_TOL_CYC) ? s_q.err_cnt :
                    s_q.err_cnt + 4'h1;
    end else begin
      s_d.err_cnt = '0;
    end
    unlock = (s_q.err_cnt == pst_pkg::LOCK_TOL_CYC);
    if (unlock) begin
      s_d.lock = 1'b1; // R19
      s_d.clean = 1'b0;
    end else if (ref_tick) begin
      if (s_q.clean) begin
        s_d.lock = 1'b0; // R19
      end
      s_d.clean = 1'b1;
    end

    // band outputs, test routing overrides bands two and three
    s_d.band_out = s_q.band;
    if (s_q.route) begin
      s_d.band_out[2] = ref_sq; // R13
      s_d.band_out[3] = half_divider_freq; // R13
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.rx <= pst_pkg::RX_IDLE; // R03
      s_q.ratio_a <= pst_pkg::POR_RATIO; // R03
      s_q.lock <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign band_switch_out = s_q.band_out;
  assign pump_up = s_q.pump_up_o;
  assign pump_down = s_q.pump_dn_o;
  assign pump_current_select = s_q.pump_low; // R10
  assign lock_out = s_q.lock;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  property p_band_at4;
    (s_q.rx == pst_pkg::RX_SHIFT) && !en_fall && !clk_rise && clk_fall &&
    (s_q.bit_cnt == pst_pkg::BAND_PULSE) |=> s_q.band == $past(s_q.shreg[3:0]);
  endproperty
  a_band_at4: assert property (p_band_at4) else $error("band latch missed pulse 4"); // R21

  property p_ratio_at19;
    (s_q.rx == pst_pkg::RX_SHIFT) && !en_fall && !clk_rise && clk_fall &&
    (s_q.bit_cnt == pst_pkg::DIV_PULSE) |=> s_q.ratio_a == $past(s_q.shreg);
  endproperty
  a_ratio_at19: assert property (p_ratio_at19) else $error("ratio latch missed pulse 19"); // R01

  property p_feat_at34;
    (s_q.rx == pst_pkg::RX_SHIFT) && !en_fall && clk_fall &&
    (s_q.bit_cnt == pst_pkg::FEAT_PULSE) |=>
    s_q.pump_low == $past(s_q.shreg[pst_pkg::POS_PUMP]) &&
    s_q.route == $past(s_q.shreg[pst_pkg::POS_ROUTE]);
  endproperty
  a_feat_at34: assert property (p_feat_at34) else $error("feature latch missed pulse 34"); // R02

  property p_short_msb;
    (s_q.rx == pst_pkg::RX_SHIFT) && en_fall && (s_q.bit_cnt == pst_pkg::SHORT_PULSE) |=>
    !s_q.ratio_a[pst_pkg::POS_SHORT_MSB] && s_q.ratio_a[13:0] == $past(s_q.shreg[13:0]);
  endproperty
  a_short_msb: assert property (p_short_msb) else $error("short frame msb not cleared"); // R22

  property p_cnt_cap;
    s_q.bit_cnt <= pst_pkg::FEAT_PULSE;
  endproperty
  a_cnt_cap: assert property (p_cnt_cap) else $error("bit count passed 34"); // R05

  property p_early_end;
    (s_q.rx == pst_pkg::RX_SHIFT) && en_fall && (s_q.bit_cnt < pst_pkg::SHORT_PULSE) |=>
    $stable(s_q.ratio_a);
  endproperty
  a_early_end: assert property (p_early_end) else $error("short frame touched ratio"); // R04

  property p_hiz;
    (!s_q.func_hi && s_q.func_lo) ##1 (!s_q.func_hi && s_q.func_lo) |-> !pump_up && !pump_down;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pump driven in high impedance mode"); // R11

  property p_unlock;
    unlock |=> lock_out ##1 lock_out;
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock output not raised on unlock"); // R19

  property p_route;
    s_q.route |=> band_switch_out[3] == $past(half_divider_freq);
  endproperty
  a_route: assert property (p_route) else $error("half divider not routed to band 3"); // R13

  property p_ref_wrap;
    !FIXED_REF_1024 && !s_q.ref_sel && (s_q.ref_cnt == pst_pkg::REF_TOP_LO) |=>
    s_q.ref_cnt == 10'h000;
  endproperty
  a_ref_wrap: assert property (p_ref_wrap) else $error("reference period not 512"); // R15

  property p_ref_wrap_hi;
    (FIXED_REF_1024 || s_q.ref_sel) && (s_q.ref_cnt == pst_pkg::REF_TOP_HI) |=>
    s_q.ref_cnt == 10'h000;
  endproperty
  a_ref_wrap_hi: assert property (p_ref_wrap_hi) else $error("ref period not 1024"); // R15

  // a frame ending after 18 to 33 pulses must fall back to the standard reference ratio
  property p_ref_std;
    (s_q.rx == pst_pkg::RX_SHIFT) && en_fall && (s_q.bit_cnt >= pst_pkg::SHORT_PULSE) &&
    (s_q.bit_cnt < pst_pkg::FEAT_PULSE) |=> !s_q.ref_sel;
  endproperty
  a_ref_std: assert property (p_ref_std) else $error("short frame kept ref 1024"); // R15

  property p_offset;
    ref_tick ##1 (!s_q.func_hi && !s_q.func_lo) ##1
    (!s_q.func_hi && !s_q.func_lo) |-> pump_up;
  endproperty
  a_offset: assert property (p_offset) else $error("offset pulse missing"); // R12

  // once the count is full, further pulses must leave the shift register alone
  property p_drop_after34;
    (s_q.rx == pst_pkg::RX_SHIFT) && clk_rise && (s_q.bit_cnt == pst_pkg::FEAT_PULSE) |=>
    $stable(s_q.shreg);
  endproperty
  a_drop_after34: assert property (p_drop_after34) else $error("bit past 34 shifted"); // R05

  property p_ratio_hold;
    (s_q.rx == pst_pkg::RX_SHIFT) && en_fall && (s_q.bit_cnt > pst_pkg::SHORT_PULSE) |=>
    $stable(s_q.ratio_a);
  endproperty
  a_ratio_hold: assert property (p_ratio_hold) else $error("ratio moved late"); // R22

  property p_band_hold;
    !s_q.route |=> band_switch_out == $past(s_q.band);
  endproperty
  a_band_hold: assert property (p_band_hold) else $error("band output not latch"); // R13

  property p_lock_fall;
    $fell(lock_out) |-> $past(ref_tick) && !$past(unlock);
  endproperty
  a_lock_fall: assert property (p_lock_fall) else $error("lock fell off period"); // R19

  c_long_frame: cover property (clk_fall && s_q.bit_cnt == pst_pkg::FEAT_PULSE);
  c_short_frame: cover property (en_fall && s_q.bit_cnt == pst_pkg::SHORT_PULSE);
  c_locked: cover property ($fell(lock_out));
  c_route: cover property (s_q.route && ref_tick);

endmodule

//--- dv/pst_mcu_model.sv
// serial controller model driving the three-wire tuning bus
// assumes clock is the 10 MHz device clock; pins change on its falling edge
`timescale 1ns/1ps
module pst_mcu_model (
  input wire logic clock,
  output logic serial_in_line,
  output logic serial_shift_clock,
  output logic serial_enable
);
  // four cycles per phase keeps every pin above the three-flop filter
  localparam int HOLD = 4;

  initial begin
    serial_in_line = 1'b0;
    serial_shift_clock = 1'b0;
    serial_enable = 1'b0;
  end

  task automatic pause();
    repeat (HOLD) @(negedge clock);
  endtask

  // frame is left aligned: bit 39 goes out first
  task automatic send_frame(input logic [39:0] frame, input int nbits);
    serial_enable = 1'b1;
    pause();
    for (int i = 0; i < nbits; i++) begin
      serial_in_line = frame[39 - i];
      pause();
      serial_shift_clock = 1'b1;
      pause();
      serial_shift_clock = 1'b0;
      pause();
    end
    serial_enable = 1'b0;
    pause();
    // a released data line must not keep showing the last bit
    serial_in_line = ~serial_in_line;
  endtask
endmodule

//--- dv/pst_ctrl_tb.sv
// self-checking bench for the tuning control block
// assumes the controller model owns the serial pins; hf input toggles freely
`timescale 1ns/1ps
module pst_ctrl_tb;
  logic clock;
  logic arst_n;
  logic hf_in;
  logic serial_in_line;
  logic serial_shift_clock;
  logic serial_enable;
  logic [3:0] band_switch_out;
  logic pump_up;
  logic pump_down;
  logic pump_current_select;
  logic lock_out;
  logic [3:0] m_band;
  logic m_sel;
  logic [1:0] m_func;
  logic m_route;
  int bad_count;
  int samples_checked;
  int rnd;

  pst_ctrl #(.FIXED_REF_1024(1'b0)) pst_ctrl_i (
    .clock(clock), .arst_n(arst_n), .serial_in_line(serial_in_line),
    .serial_shift_clock(serial_shift_clock), .serial_enable(serial_enable),
    .hf_in(hf_in), .band_switch_out(band_switch_out), .pump_up(pump_up),
    .pump_down(pump_down), .pump_current_select(pump_current_select),
    .lock_out(lock_out)
  );

  pst_mcu_model pst_mcu_model_i (
    .clock(clock), .serial_in_line(serial_in_line),
    .serial_shift_clock(serial_shift_clock), .serial_enable(serial_enable)
  );

  initial clock = 1'b0;
  always #50 clock = ~clock;
  // each level held four cycles so the pin filter passes every edge
  always begin
    repeat (4) @(negedge clock);
    hf_in <= ~hf_in;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check_all();
    // routing replaces bands two and three, so only the low bands stay latched
    if (m_route)
      chk("band low", 16'(m_band[1:0]), 16'(band_switch_out[1:0]));
    else
      chk("band", 16'(m_band), 16'(band_switch_out));
    chk("current", 16'(m_sel), 16'(pump_current_select));
    // normal mode pumps follow the loop, so only forced modes are predictable
    if (m_func != 2'b00) begin
      chk("up", 16'(m_func == 2'b10), 16'(pump_up));
      chk("down", 16'(m_func == 2'b11), 16'(pump_down));
    end
  endtask

  // reference square on band two toggles every half reference period
  task automatic ref_check(input int half);
    int last;
    int seen;
    logic prev;
    last = -1;
    seen = 0;
    prev = band_switch_out[2];
    for (int i = 0; i < 4 * half + 8; i++) begin
      @(negedge clock);
      if (band_switch_out[2] !== prev) begin
        prev = band_switch_out[2];
        if (last >= 0) chk("ref half period", 16'(half), 16'(i - last));
        last = i;
        seen++;
      end
    end
    chk("ref square", 16'h0001, 16'(seen >= 3));
    chk("low bands", 16'(m_band[1:0]), 16'(band_switch_out[1:0]));
  endtask

  // send a frame, update the model from the bits that reached each latch
  task automatic frame(input logic [39:0] f, input int nb);
    pst_mcu_model_i.send_frame(f, nb);
    if (nb >= 4) m_band = f[39:36];
    if (nb >= 34) begin
      m_sel = f[14];
      m_func = f[16:15];
      m_route = f[18];
    end
    repeat (10) @(negedge clock);
    check_all();
  endtask

  function automatic logic [39:0] mk(logic [3:0] b, logic [6:0] t);
    logic [14:0] n;
    n = 15'(17 + ($urandom % 32751));
    return {b, n, t, 8'($urandom), 6'($urandom)};
  endfunction

  task automatic do_reset();
    arst_n = 1'b0;
    m_band = 4'h0;
    m_sel = 1'b0;
    m_func = 2'b00;
    m_route = 1'b0;
    repeat (4) @(negedge clock);
    chk("up rst", 16'h0000, 16'(pump_up));
    chk("down rst", 16'h0000, 16'(pump_down));
    chk("lock rst", 16'h0001, 16'(lock_out));
    check_all();
    repeat (4) @(negedge clock);
    arst_n = 1'b1;
  endtask

  initial begin
    hf_in = 1'b0;
    arst_n = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    rnd = $urandom(32'hf863);
    do_reset();
    repeat (8) @(negedge clock);
    for (int k = 0; k < 4; k++) begin
      // route bit kept low; last pass adds six bits past the limit
      frame(mk(4'($urandom), {1'($urandom), 2'b00, 1'($urandom), 2'(k), 1'($urandom)}),
        (k == 3) ? 40 : 34);
    end
    frame(mk(4'($urandom), 7'($urandom)), 9);
    frame(mk(4'($urandom), 7'($urandom)), 2);
    // short frame ratio kept between 17 and 16363
    frame({4'($urandom), 14'(17 + ($urandom % 16347)), 22'($urandom)}, 18);
    frame(mk(4'($urandom), 7'($urandom)), 19);
    // routing also needs band bits two and three set in the same frame
    frame(mk(4'hc, 7'b0010000), 34);
    ref_check(256);
    frame(mk(4'hc, 7'b0110000), 34);
    ref_check(512);
    frame(mk(4'hc, 7'($urandom)), 19);
    ref_check(256);
    frame(mk(4'($urandom), 7'($urandom) & 7'b1101111), 34);
    do_reset();
    repeat (8) @(negedge clock);
    frame(mk(4'($urandom), 7'($urandom)), 19);
    final_report();
  end

  initial begin
    repeat (100000) @(posedge clock);
    bad_count++;
    final_report();
  end
endmodule
